// ### design/accr_pkg.sv
// converter core control register bank: addresses, fields, codes, types
// assumes a serial host that sends a 16-bit header then one data byte
//
// How it works
// R1 - channel-select bit 1 lets second channel take writes
// R2 - channel-select bit 0 lets first channel take writes
// R3 - writing reset bit pulses digital logic reset
// R4 - power codes: 00/11 run, 01 off, 10 sleep
// R5 - single-ended pin choice: 0 negative, 1 positive
// R6 - clock style: 0 differential, 1 single-ended
// R7 - clock halving enable divides sample clock by two
// R8 - duty stabilizer enable switches the stabilizer
// R9 - enabled reference code sets full scale attenuation
// R10 - six-bit signed offset added to output codes
// R11 - pattern selector replaces samples with fixed patterns
// R12 - selector code 101 outputs the custom word
// R13 - high custom register gives word bits 13..6
// R14 - low custom register upper bits give bits 5..0
// R15 - low custom field sits at bits 7..2
// R16 - reserved bits ignore writes, read fixed constants
package accr_pkg;
   // ==========================================================
   // serial frame layout
   localparam int          ADDR_W      = 13;
   localparam int          SMP_W       = 14;
   localparam int          NUM_CH      = 2;
   localparam logic [4:0]  HDR_LAST    = 5'h0f;
   localparam logic [4:0]  FRAME_LAST  = 5'h17;
   localparam logic [4:0]  FRAME_END   = 5'h18;
   localparam int          RW_POS      = 15;
   // ==========================================================
   // register addresses
   localparam logic [12:0] ADDR_CHAN   = 13'h0003;
   localparam logic [12:0] ADDR_RSTPWR = 13'h0005;
   localparam logic [12:0] ADDR_CLK    = 13'h0006;
   localparam logic [12:0] ADDR_REF    = 13'h0008;
   localparam logic [12:0] ADDR_OFS    = 13'h0013;
   localparam logic [12:0] ADDR_PAT    = 13'h0014;
   localparam logic [12:0] ADDR_CUSTH  = 13'h0015;
   localparam logic [12:0] ADDR_CUSTL  = 13'h0016;
   // ==========================================================
   // field positions and constants
   localparam int          CH_A_BIT    = 0;
   localparam int          CH_B_BIT    = 1;
   localparam int          DIGITAL_LOGIC_RESET_BIT  = 7;
   localparam int          SINGLE_ENDED_PIN_CHOICE_BIT  = 4;
   localparam int          STYLE_BIT   = 3;
   localparam int          DIV2_BIT    = 1;
   localparam int          DCS_BIT     = 0;
   localparam int          REF_EN_BIT  = 3;
   localparam int          CUSTL_LSB   = 2;
   localparam logic [5:0]  CHAN_RSVD   = 6'h3f;
   localparam logic [1:0]  CHAN_RST    = 2'h3;
   localparam logic [1:0]  PWR_OFF     = 2'h1;
   localparam logic [1:0]  PWR_SLEEP   = 2'h2;
   localparam logic [1:0]  PWR_RST     = 2'h0;
   // ==========================================================
   // test pattern codes and words (offset binary output)
   localparam logic [2:0]  PAT_OFF     = 3'h0;
   localparam logic [2:0]  PAT_MID     = 3'h1;
   localparam logic [2:0]  PAT_NEGFS   = 3'h2;
   localparam logic [2:0]  PAT_POSFS   = 3'h3;
   localparam logic [2:0]  PAT_TOGGLE  = 3'h4;
   localparam logic [2:0]  PAT_CUSTOM  = 3'h5;
   localparam logic [2:0]  PAT_ALT01   = 3'h6;
   localparam logic [2:0]  PAT_ALT10   = 3'h7;
   localparam logic [13:0] WORD_MID    = 14'h2000;
   localparam logic [13:0] WORD_NEGFS  = 14'h0000;
   localparam logic [13:0] WORD_POSFS  = 14'h3fff;
   localparam logic [13:0] WORD_ALT01  = 14'h1555;
   localparam logic [13:0] WORD_ALT10  = 14'h2aaa;
   localparam logic [15:0] SUM_MAX     = 16'h3fff;
   // ==========================================================
   // carriers
   typedef struct packed {
      logic single_ended_pin_choice;
      logic clock_input_style;
      logic clock_halving_enable;
      logic duty_stabilizer_enable;
   } accr_clk_cfg_t;
   typedef struct packed {
      logic        internal_reference_enable;
      logic [2:0]  reference_gain_code;
      logic [5:0]  output_offset_value;
      logic [2:0]  pattern_selector;
      logic [7:0]  custom_word_high;
      logic [5:0]  custom_word_low;
   } accr_chan_cfg_t;
endpackage

// ### design/accr_regs.sv
// converter core control registers behind the serial port, plus the
// per-channel offset and test pattern stage on the sample path
// assumes serial pins and samples are synchronous to CLK_SYS
`timescale 1ns/1ps
`default_nettype none
module accr_regs #(
   parameter logic DCS_RESET = 1'b0
) (
   input  wire logic                     CLK_SYS,
   input  wire logic                     RST_N,
   input  wire logic                     SPI_SCLK,
   input  wire logic                     SPI_CS_N,
   input  wire logic                     SPI_SDIO_I,
   output logic                          SPI_SDIO_O,
   output logic                          SPI_SDIO_OE,
   output logic                          DIGITAL_LOGIC_RESET,
   output logic                          POWER_DOWN,
   output logic                          SLEEP,
   output accr_pkg::accr_clk_cfg_t       CLK_CFG,
   output accr_pkg::accr_chan_cfg_t      CHAN_CFG [2],
   input  wire logic [13:0]              SAMPLE_IN [2],
   output logic [13:0]                   DATA_OUT [2]
);
   import accr_pkg::*;

   // ==========================================================
   // serial shifter
   logic                sclk_q;
   logic [4:0]          bit_cnt;
   logic [15:0]         shift;
   logic                is_read;
   logic [12:0]         addr;
   logic [7:0]          rd_shift;
   logic [1:0]          chan_sel;
   logic [1:0]          power_state;
   accr_clk_cfg_t       clk_cfg;
   accr_chan_cfg_t      chan [NUM_CH];

   wire        rise       = SPI_SCLK & ~sclk_q & ~SPI_CS_N;
   wire        fall       = ~SPI_SCLK & sclk_q & ~SPI_CS_N;
   wire [15:0] next_shift = {shift[14:0], SPI_SDIO_I};
   wire        hdr_done   = rise && (bit_cnt == HDR_LAST);
   wire        wr         = rise && (bit_cnt == FRAME_LAST) && !is_read;
   wire [7:0]  wdata      = next_shift[7:0];
   wire        digital_logic_reset     = wr && (addr == ADDR_RSTPWR) && wdata[DIGITAL_LOGIC_RESET_BIT];
   wire        rd_phase   = is_read && (bit_cnt > HDR_LAST)
                            && (bit_cnt < FRAME_END);
   // reads show the first selected channel, second one otherwise
   wire        rd_ch      = ~chan_sel[CH_A_BIT];

   function automatic logic hit(input logic [12:0] a,
                                input logic [12:0] want);
      hit = (a == want);
   endfunction

   function automatic logic [7:0] rd_value(input logic [12:0] a);
      accr_chan_cfg_t c;
      c = chan[rd_ch];
      rd_value = 8'h00;
      if (hit(a, ADDR_CHAN))
         rd_value = {CHAN_RSVD, chan_sel};                         // R16
      if (hit(a, ADDR_RSTPWR))
         rd_value = {6'h00, power_state};
      if (hit(a, ADDR_CLK))
         rd_value = {3'h0, clk_cfg.single_ended_pin_choice,
                     clk_cfg.clock_input_style, 1'b0,
                     clk_cfg.clock_halving_enable,
                     clk_cfg.duty_stabilizer_enable};
      if (hit(a, ADDR_REF))
         rd_value = {4'h0, c.internal_reference_enable,
                     c.reference_gain_code};
      if (hit(a, ADDR_OFS))
         rd_value = {2'h0, c.output_offset_value};
      if (hit(a, ADDR_PAT))
         rd_value = {5'h00, c.pattern_selector};
      if (hit(a, ADDR_CUSTH))
         rd_value = c.custom_word_high;
      if (hit(a, ADDR_CUSTL))
         rd_value = {c.custom_word_low, 2'h0};                     // R15
   endfunction

   always_ff @(posedge CLK_SYS) begin
      if (!RST_N) begin
         sclk_q <= 1'b0;
      end else begin
         sclk_q <= SPI_SCLK;
      end
   end

   // a frame is header plus one byte; extra clocks in a frame are ignored
   always_ff @(posedge CLK_SYS) begin
      if (!RST_N || SPI_CS_N) begin
         bit_cnt <= 5'h00;
         shift   <= 16'h0000;
      end else if (rise && bit_cnt != FRAME_END) begin
         bit_cnt <= bit_cnt + 5'h01;
         shift   <= next_shift;
      end
   end

   always_ff @(posedge CLK_SYS) begin
      if (!RST_N) begin
         is_read <= 1'b0;
         addr    <= 13'h0000;
      end else if (hdr_done) begin
         is_read <= next_shift[RW_POS];
         addr    <= next_shift[ADDR_W-1:0];
      end
   end

   // read byte leaves msb first, changing on falling serial edges
   always_ff @(posedge CLK_SYS) begin
      if (!RST_N || SPI_CS_N) begin
         rd_shift    <= 8'h00;
         SPI_SDIO_O  <= 1'b0;
         SPI_SDIO_OE <= 1'b0;
      end else if (hdr_done) begin
         rd_shift <= rd_value(next_shift[ADDR_W-1:0]);
      end else if (fall) begin
         SPI_SDIO_OE <= rd_phase;
         if (rd_phase) begin
            SPI_SDIO_O <= rd_shift[7];
            rd_shift   <= {rd_shift[6:0], 1'b0};
         end
      end
   end

   // ==========================================================
   // shared registers; software reset restores every default
   always_ff @(posedge CLK_SYS) begin
      if (!RST_N || digital_logic_reset) begin                                 // R3
         chan_sel    <= CHAN_RST;
         power_state <= PWR_RST;
         clk_cfg     <= '{1'b0, 1'b0, 1'b0, DCS_RESET};
      end else if (wr) begin
         if (hit(addr, ADDR_CHAN))
            chan_sel <= wdata[1:0];
         if (hit(addr, ADDR_RSTPWR))
            power_state <= wdata[1:0];
         if (hit(addr, ADDR_CLK)) begin
            clk_cfg.single_ended_pin_choice <= wdata[SINGLE_ENDED_PIN_CHOICE_BIT]; // R5
            clk_cfg.clock_input_style       <= wdata[STYLE_BIT];  // R6
            clk_cfg.clock_halving_enable    <= wdata[DIV2_BIT];   // R7
            clk_cfg.duty_stabilizer_enable  <= wdata[DCS_BIT];    // R8
         end
      end
   end

   always_ff @(posedge CLK_SYS) begin
      if (!RST_N) begin
         DIGITAL_LOGIC_RESET <= 1'b0;
         POWER_DOWN          <= 1'b0;
         SLEEP               <= 1'b0;
      end else begin
         DIGITAL_LOGIC_RESET <= digital_logic_reset;                           // R3
         POWER_DOWN          <= (power_state == PWR_OFF);         // R4
         SLEEP               <= (power_state == PWR_SLEEP);       // R4
      end
   end

   assign CLK_CFG = clk_cfg;

   // ==========================================================
   // per-channel registers and output stage
   genvar g;
   generate
      for (g = 0; g < NUM_CH; g++) begin : gen_ch
         localparam int SEL_BIT = (g == 0) ? CH_A_BIT : CH_B_BIT;
         logic        toggle;
         logic [15:0] sum;
         logic [13:0] adj;
         logic [13:0] next_data;
         // unselected channel ignores the command
         wire   take = wr && chan_sel[SEL_BIT];                   // R1 R2
         wire [13:0] custom = {chan[g].custom_word_high,
                               chan[g].custom_word_low};          // R12

         always_ff @(posedge CLK_SYS) begin
            if (!RST_N || digital_logic_reset) begin
               chan[g] <= '0;                                     // R3
            end else if (take) begin
               if (hit(addr, ADDR_REF)) begin
                  chan[g].internal_reference_enable <= wdata[REF_EN_BIT];
                  chan[g].reference_gain_code       <= wdata[2:0]; // R9
               end
               if (hit(addr, ADDR_OFS))
                  chan[g].output_offset_value <= wdata[5:0];      // R10
               if (hit(addr, ADDR_PAT))
                  chan[g].pattern_selector <= wdata[2:0];         // R11
               if (hit(addr, ADDR_CUSTH))
                  chan[g].custom_word_high <= wdata;              // R13
               if (hit(addr, ADDR_CUSTL))
                  chan[g].custom_word_low <= wdata[7:CUSTL_LSB];  // R14 R15
            end
         end

         // offset is signed, added in lsb units and clipped to code range
         assign sum = {2'h0, SAMPLE_IN[g]}
                    + {{10{chan[g].output_offset_value[5]}},
                       chan[g].output_offset_value};              // R10
         assign adj = sum[15] ? WORD_NEGFS :
                      (sum > SUM_MAX) ? WORD_POSFS : sum[13:0];

         always_comb begin
            case (chan[g].pattern_selector)                       // R11
               PAT_OFF:    next_data = adj;
               PAT_MID:    next_data = WORD_MID;
               PAT_NEGFS:  next_data = WORD_NEGFS;
               PAT_POSFS:  next_data = WORD_POSFS;
               PAT_TOGGLE: next_data = toggle ? WORD_POSFS : WORD_NEGFS;
               PAT_CUSTOM: next_data = custom;                    // R12
               PAT_ALT01:  next_data = WORD_ALT01;
               PAT_ALT10:  next_data = WORD_ALT10;
               default:    next_data = adj;
            endcase
         end

         always_ff @(posedge CLK_SYS) begin
            if (!RST_N) begin
               toggle      <= 1'b0;
               DATA_OUT[g] <= WORD_NEGFS;
            end else begin
               toggle      <= ~toggle;
               DATA_OUT[g] <= next_data;
            end
         end
         assign CHAN_CFG[g] = chan[g];
      end
   endgenerate

   // ==========================================================
   // checks
   default clocking cb @(posedge CLK_SYS); endclocking
   default disable iff (!RST_N);

   chan_b_ignore_a: assert property ( // R1
      wr && !chan_sel[CH_B_BIT] && hit(addr, ADDR_PAT)
      |=> $stable(CHAN_CFG[1].pattern_selector))
      else $error("second channel took an unselected write");
   chan_a_take_a: assert property ( // R2
      wr && chan_sel[CH_A_BIT] && hit(addr, ADDR_OFS) && !digital_logic_reset
      |=> CHAN_CFG[0].output_offset_value == $past(wdata[5:0]))
      else $error("first channel missed a selected write");
   soft_reset_a: assert property ( // R3
      digital_logic_reset |=> DIGITAL_LOGIC_RESET
      ##1 !DIGITAL_LOGIC_RESET && !POWER_DOWN && !SLEEP)
      else $error("software reset did not pulse and clear");
   power_decode_a: assert property ( // R4
      wr && hit(addr, ADDR_RSTPWR) && !wdata[DIGITAL_LOGIC_RESET_BIT]
      && wdata[1:0] == PWR_OFF |=> ##1 POWER_DOWN && !SLEEP)
      else $error("full power-down not decoded");
   clock_field_a: assert property ( // R5 R6 R7 R8
      wr && hit(addr, ADDR_CLK) |=> CLK_CFG == {$past(wdata[SINGLE_ENDED_PIN_CHOICE_BIT]),
      $past(wdata[STYLE_BIT]), $past(wdata[DIV2_BIT]),
      $past(wdata[DCS_BIT])})
      else $error("clock control fields not applied");
   ref_code_a: assert property ( // R9
      wr && chan_sel[CH_A_BIT] && hit(addr, ADDR_REF)
      |=> CHAN_CFG[0].reference_gain_code == $past(wdata[2:0]))
      else $error("reference code not stored");
   offset_zero_a: assert property ( // R10
      CHAN_CFG[0].pattern_selector == PAT_OFF
      && CHAN_CFG[0].output_offset_value == 6'h00
      |=> DATA_OUT[0] == $past(SAMPLE_IN[0]))
      else $error("zero offset changed the sample");
   pattern_fs_a: assert property ( // R11
      CHAN_CFG[0].pattern_selector == PAT_POSFS
      |=> DATA_OUT[0] == WORD_POSFS)
      else $error("positive full scale pattern wrong");
   custom_word_a: assert property ( // R12 R13 R14 R15
      CHAN_CFG[0].pattern_selector == PAT_CUSTOM
      |=> DATA_OUT[0] == {$past(CHAN_CFG[0].custom_word_high),
                          $past(CHAN_CFG[0].custom_word_low)})
      else $error("custom pattern word wrong");
   reserved_read_a: assert property ( // R16
      hdr_done && !SPI_CS_N && next_shift[RW_POS]
      && next_shift[ADDR_W-1:0] == ADDR_CHAN
      |=> rd_shift[7:2] == CHAN_RSVD)
      else $error("reserved channel bits read wrong");

   // channel steering
   chan_b_take_a: assert property ( // R1
      wr && chan_sel[CH_B_BIT] && hit(addr, ADDR_REF)
      |=> CHAN_CFG[1].reference_gain_code == $past(wdata[2:0]))
      else $error("second channel missed a selected write");
   chan_a_ignore_a: assert property ( // R2
      wr && !chan_sel[CH_A_BIT] && hit(addr, ADDR_REF)
      |=> $stable(CHAN_CFG[0].reference_gain_code))
      else $error("first channel took an unselected write");
   ref_enable_a: assert property ( // R9
      wr && chan_sel[CH_A_BIT] && hit(addr, ADDR_REF)
      |=> CHAN_CFG[0].internal_reference_enable == $past(wdata[REF_EN_BIT]))
      else $error("reference enable not stored");
   custom_high_a: assert property ( // R13
      wr && chan_sel[CH_A_BIT] && hit(addr, ADDR_CUSTH)
      |=> CHAN_CFG[0].custom_word_high == $past(wdata))
      else $error("high custom byte not stored");
   custom_low_a: assert property ( // R14 R15
      wr && chan_sel[CH_A_BIT] && hit(addr, ADDR_CUSTL)
      |=> CHAN_CFG[0].custom_word_low == $past(wdata[7:CUSTL_LSB]))
      else $error("low custom field not stored");

   // power and software reset
   sleep_decode_a: assert property ( // R4
      wr && hit(addr, ADDR_RSTPWR) && !wdata[DIGITAL_LOGIC_RESET_BIT]
      && wdata[1:0] == PWR_SLEEP |=> ##1 SLEEP && !POWER_DOWN)
      else $error("sleep not decoded");
   power_run_a: assert property ( // R4
      wr && hit(addr, ADDR_RSTPWR) && !wdata[DIGITAL_LOGIC_RESET_BIT]
      && wdata[0] == wdata[1] |=> ##1 !SLEEP && !POWER_DOWN)
      else $error("normal power code not decoded");
   reset_clear_a: assert property ( // R3
      digital_logic_reset |=> CHAN_CFG[0] == '0 && CHAN_CFG[1] == '0)
      else $error("software reset left channel settings");

   // output stage
   pattern_mid_a: assert property ( // R11
      CHAN_CFG[0].pattern_selector == PAT_MID
      |=> DATA_OUT[0] == WORD_MID)
      else $error("mid-scale pattern wrong");
   pattern_negfs_a: assert property ( // R11
      CHAN_CFG[0].pattern_selector == PAT_NEGFS
      |=> DATA_OUT[0] == WORD_NEGFS)
      else $error("negative full scale pattern wrong");
   pattern_toggle_a: assert property ( // R11
      CHAN_CFG[0].pattern_selector == PAT_TOGGLE
      && $past(CHAN_CFG[0].pattern_selector) == PAT_TOGGLE
      |=> DATA_OUT[0] == ~$past(DATA_OUT[0]))
      else $error("toggle pattern did not alternate");
   pattern_alt01_a: assert property ( // R11
      CHAN_CFG[0].pattern_selector == PAT_ALT01
      |=> DATA_OUT[0] == WORD_ALT01)
      else $error("first alternating pattern wrong");
   pattern_alt10_a: assert property ( // R11
      CHAN_CFG[0].pattern_selector == PAT_ALT10
      |=> DATA_OUT[0] == WORD_ALT10)
      else $error("second alternating pattern wrong");
   offset_down_a: assert property ( // R10
      CHAN_CFG[0].pattern_selector == PAT_OFF
      && CHAN_CFG[0].output_offset_value[5]
      |=> DATA_OUT[0] <= $past(SAMPLE_IN[0]))
      else $error("negative offset raised the sample");
   offset_up_a: assert property ( // R10
      CHAN_CFG[0].pattern_selector == PAT_OFF
      && !CHAN_CFG[0].output_offset_value[5]
      |=> DATA_OUT[0] >= $past(SAMPLE_IN[0]))
      else $error("positive offset lowered the sample");
endmodule
`default_nettype wire

// ### tb/accr_host.sv
// serial host model that configures the converter core register bank
// assumes the bench merges host drive and device drive onto one wire
`timescale 1ns/1ps
`default_nettype none
module accr_host (
   input  wire logic clk_sys,
   output logic      sclk,
   output logic      cs_n,
   output logic      sdio_drv,
   input  wire logic sdio_o,
   input  wire logic sdio_oe
);
   // ==========================================================
   // frame engine
   initial begin
      sclk     = 1'b0;
      cs_n     = 1'b1;
      sdio_drv = 1'b0;
   end

   // one byte per frame, header msb first, clock high held three cycles, low three
   task automatic xfer(input logic rd, input logic [12:0] addr,
                       input logic [7:0] wdata, output logic [7:0] rdata);
      logic [23:0] frame;
      frame = {rd, 2'b00, addr, wdata};
      rdata = 8'h00;
      @(negedge clk_sys);
      cs_n = 1'b0;
      for (int i = 23; i >= 0; i--) begin
         @(negedge clk_sys);
         if (rd && i < 8) begin
            // released line wiggles so a stale level cannot pass
            rdata[i] = sdio_oe ? sdio_o : 1'bx;
            sdio_drv = ~sdio_drv;
         end else begin
            sdio_drv = frame[i];
         end
         sclk = 1'b1;
         repeat (3) @(negedge clk_sys);
         sclk = 1'b0;
         repeat (2) @(negedge clk_sys);
      end
      @(negedge clk_sys);
      cs_n = 1'b1;
      repeat (2) @(negedge clk_sys);
   endtask
endmodule
`default_nettype wire

// ### tb/tb.sv
// self-checking bench for the converter core register bank
// assumes the host model and the design share CLK_SYS
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin \
   err_count++; $display("[FAIL] %s exp %h got %h", n, e, g); end end
module tb;
   import accr_pkg::*;
   // ==========================================================
   // signals
   logic            clk_sys = 1'b0;
   logic            rst_n;
   logic            sclk, cs_n, host_drv, sdio_o, sdio_oe;
   logic            logic_rst, pwr_down, sleep_o;
   wire             sdio_wire;
   accr_clk_cfg_t   clk_cfg;
   accr_chan_cfg_t  chan_cfg [2];
   logic [13:0]     sample_in [2];
   logic [13:0]     data_out [2];
   logic [7:0]      rd;
   int              err_count, samples_checked, cycles, pulses;
   localparam logic [12:0] ADDRS [8] = '{ADDR_CHAN, ADDR_RSTPWR,
      ADDR_CLK, ADDR_REF, ADDR_OFS, ADDR_PAT, ADDR_CUSTH, ADDR_CUSTL};

   always #2.5 clk_sys = ~clk_sys;
   assign sdio_wire = sdio_oe ? sdio_o : host_drv;

   accr_regs i_dut (.CLK_SYS(clk_sys), .RST_N(rst_n), .SPI_SCLK(sclk),
      .SPI_CS_N(cs_n), .SPI_SDIO_I(sdio_wire), .SPI_SDIO_O(sdio_o),
      .SPI_SDIO_OE(sdio_oe), .DIGITAL_LOGIC_RESET(logic_rst),
      .POWER_DOWN(pwr_down), .SLEEP(sleep_o), .CLK_CFG(clk_cfg),
      .CHAN_CFG(chan_cfg), .SAMPLE_IN(sample_in), .DATA_OUT(data_out));
   accr_host i_host (.clk_sys(clk_sys), .sclk(sclk), .cs_n(cs_n),
      .sdio_drv(host_drv), .sdio_o(sdio_o), .sdio_oe(sdio_oe));

   // ==========================================================
   // helpers
   task automatic close_out;
      if (err_count == 0 && samples_checked > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   // ceiling well above the roughly 8600 cycles the scenarios need
   always @(posedge clk_sys) begin
      cycles++;
      if (logic_rst === 1'b1) pulses++;
      if (cycles == 30000) begin
         err_count++;
         close_out();
      end
   end

   task automatic wr(input logic [12:0] a, input logic [7:0] d);
      i_host.xfer(1'b0, a, d, rd);
      repeat (4) @(negedge clk_sys);
   endtask

   task automatic rdchk(input string n, input logic [12:0] a,
                        input logic [7:0] e);
      i_host.xfer(1'b1, a, 8'h00, rd);
      `CHK(n, e, rd)
   endtask

   // ==========================================================
   // scenarios
   task automatic t_reset_values;
      for (int i = 0; i < 8; i++)
         rdchk("reset value", ADDRS[i], i == 0 ? 8'hff : 8'h00);
      `CHK("clk cfg", 4'h0, clk_cfg)
      wr(13'h0007, 8'hff);
      rdchk("unmapped", 13'h0007, 8'h00);
   endtask

   task automatic t_clock;
      logic [7:0] w [4] = '{8'h10, 8'h08, 8'h02, 8'h01};
      wr(ADDR_CLK, 8'hff);
      `CHK("clk all", 4'hf, clk_cfg)
      rdchk("clk read", ADDR_CLK, 8'h1b);
      for (int i = 0; i < 4; i++) begin
         wr(ADDR_CLK, w[i]);
         `CHK("clk bit", 4'h8 >> i, clk_cfg)
      end
   endtask

   task automatic t_power;
      for (int c = 3; c >= 0; c--) begin
         wr(ADDR_RSTPWR, 8'h7c | 8'(c));
         `CHK("power down", c == 1, pwr_down)
         `CHK("sleep", c == 2, sleep_o)
         rdchk("power read", ADDR_RSTPWR, 8'(c));
      end
      `CHK("no reset pulse", 0, pulses)
   endtask

   task automatic t_channels;
      wr(ADDR_CHAN, 8'h01);
      wr(ADDR_REF, 8'hfb);
      `CHK("first ref", 4'hb, chan_cfg[0][26:23])
      `CHK("second ref", 4'h0, chan_cfg[1][26:23])
      rdchk("ref read", ADDR_REF, 8'h0b);
      wr(ADDR_PAT, 8'h03);
      `CHK("first pat", WORD_POSFS, data_out[0])
      `CHK("second pat", 14'h0000, data_out[1])
      wr(ADDR_CHAN, 8'h02);
      rdchk("chan read", ADDR_CHAN, 8'hfe);
      wr(ADDR_REF, 8'h0f);
      `CHK("second code", 3'h7, chan_cfg[1].reference_gain_code)
      `CHK("first kept", 3'h3, chan_cfg[0].reference_gain_code)
      rdchk("ref second", ADDR_REF, 8'h0f);
      wr(ADDR_CHAN, 8'h03);
   endtask

   task automatic t_patterns;
      logic [13:0] ex [8] = '{14'h1234, WORD_MID, WORD_NEGFS, WORD_POSFS,
         14'h0, {8'ha5, 6'h3f}, WORD_ALT01, WORD_ALT10};
      logic [13:0] a;
      sample_in = '{14'h1234, 14'h0abc};
      wr(ADDR_CUSTH, 8'ha5);
      wr(ADDR_CUSTL, 8'hff);
      rdchk("cust low", ADDR_CUSTL, 8'hfc);
      rdchk("cust high", ADDR_CUSTH, 8'ha5);
      for (int c = 7; c >= 0; c--) begin
         wr(ADDR_PAT, 8'hf8 | 8'(c));
         if (c == 4) begin
            a = data_out[0];
            @(negedge clk_sys);
            `CHK("toggle", 14'h3fff, a ^ data_out[0])
            `CHK("toggle lvl", 1'b1, a == 14'h0 || a == 14'h3fff)
         end else begin
            `CHK("pattern a", ex[c], data_out[0])
            `CHK("pattern b", c == 0 ? 14'h0abc : ex[c], data_out[1])
         end
      end
   endtask

   task automatic t_offset;
      logic [13:0] s [5] = '{14'h1234, 14'h1234, 14'h3ff0, 14'h0010, 14'h5};
      logic [5:0]  o [5] = '{6'h1f, 6'h20, 6'h1f, 6'h20, 6'h00};
      logic [13:0] e [5] = '{14'h1253, 14'h1214, 14'h3fff, 14'h0, 14'h5};
      for (int i = 0; i < 5; i++) begin
         sample_in[0] = s[i];
         wr(ADDR_OFS, {2'b11, o[i]});
         `CHK("offset out", e[i], data_out[0])
      end
      rdchk("offset read", ADDR_OFS, 8'h00);
   endtask

   task automatic t_soft_reset;
      int p0;
      wr(ADDR_CUSTH, 8'h5a);
      wr(ADDR_CHAN, 8'h01);
      p0 = pulses;
      wr(ADDR_RSTPWR, 8'h81);
      `CHK("reset pulse", 1, pulses - p0)
      `CHK("power after", 1'b0, pwr_down)
      rdchk("chan after", ADDR_CHAN, 8'hff);
      rdchk("cust after", ADDR_CUSTH, 8'h00);
      rdchk("pwr after", ADDR_RSTPWR, 8'h00);
   endtask

   // ==========================================================
   // main sequence
   initial begin
      rst_n     = 1'b0;
      sample_in = '{14'h0, 14'h0};
      repeat (3) @(negedge clk_sys);
      rst_n = 1'b1;
      @(negedge clk_sys);
      t_reset_values();
      t_clock();
      t_power();
      t_channels();
      t_patterns();
      t_offset();
      t_soft_reset();
      close_out();
   end
endmodule
`default_nettype wire
